// ==== rtl/slb_defs.svh ====
// Register offsets, field positions, keys, reset values and timing counts of the
// system lock, self-test and reset-cause register bank.
// Assumes a 9-bit register address from the serial slave and 16-bit data words.
`ifndef SLB_DEFS_SVH
`define SLB_DEFS_SVH

// Register offsets on the internal register port.
`define SLB_OFS_WRITE_PROTECT   9'h1CD
`define SLB_OFS_CLEAR_ON_READ   9'h1CE
`define SLB_OFS_UNLOCK          9'h1CF
`define SLB_OFS_RESET_CAUSE     9'h1D6
`define SLB_OFS_SELFTEST        9'h1DC
// First and last diagnosis error register of the clear-on-read pairs.
`define SLB_OFS_DIAG_FIRST      9'h162
`define SLB_OFS_DIAG_LAST       9'h169
// Default offsets of the driver status and microcore status registers.
`define SLB_OFS_DRV_STATUS      9'h1D2
`define SLB_OFS_CORE_STAT_BASE  9'h1E0

// Keys.
`define SLB_KEY_SELFTEST        16'hB157
`define SLB_KEY_UNLOCK          16'h1337

// Field positions.
`define SLB_BIT_GLOBAL_LOCK     0
`define SLB_BIT_TAIL_A_LOCK     1
`define SLB_BIT_TAIL_B_LOCK     2
`define SLB_BIT_CAUSE_PIN       0
`define SLB_BIT_CAUSE_POR       1
`define SLB_BIT_CAUSE_SPI       2
`define SLB_COR_TARGETS         9

// Reset values.
`define SLB_RST_LOCK            3'h0
`define SLB_RST_COR_SEL         9'h000
`define SLB_RST_DATA            16'h0000

// Self-test run time, as a time and as cycles of the 4 ns system clock.
`define SLB_BIST_TIME_MS        2.2
`define SLB_CLK_PERIOD_NS       4
`define SLB_BIST_CYCLES         (int'((`SLB_BIST_TIME_MS * 1000000.0) / `SLB_CLK_PERIOD_NS))

`endif

// ==== rtl/slb_pkg.sv ====
// Types shared by the system lock, self-test and reset-cause register bank.
// Assumes nothing beyond a SystemVerilog tool.
package slb_pkg;
    // Outcome codes read back from the self-test register.
    typedef enum logic [1:0] {
        SLB_OUT_NEVER   = 2'h0,
        SLB_OUT_RUNNING = 2'h1,
        SLB_OUT_PASSED  = 2'h2,
        SLB_OUT_FAILED  = 2'h3
    } slb_outcome_t;

    // Self-test sequencer states.
    typedef enum logic [2:0] {
        SLB_ST_IDLE,
        SLB_ST_WRITE,
        SLB_ST_READ,
        SLB_ST_DRAIN,
        SLB_ST_HOLD
    } slb_state_t;
endpackage

// ==== rtl/slb_regs.sv ====
// System management register bank: reset-cause record, memory self-test launcher,
// write protection and clear-on-read selection.
// Assumes the serial slave presents decoded register accesses on mclk, one per cycle,
// and that the RAM under test answers a read one cycle after its address.
`include "slb_defs.svh"

module slb_regs
    import slb_pkg::*;
#(
    parameter int unsigned RAM_AW          = 8,
    parameter int unsigned RAM_DW          = 32,
    parameter int unsigned BIST_RUN_CYCLES = `SLB_BIST_CYCLES,
    parameter logic [8:0]  DRV_STATUS_OFS  = `SLB_OFS_DRV_STATUS,
    parameter logic [8:0]  CORE_STAT_BASE  = `SLB_OFS_CORE_STAT_BASE
) (
    input  wire logic                        mclk,
    input  wire logic                        reset,
    // Register port from the serial slave.
    input  wire logic [8:0]                  reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic                        reg_backdoor,
    input  wire logic [15:0]                 reg_wdata,
    output logic      [15:0]                 reg_rdata_r,
    // Reset sources, levels from the reset generator.
    input  wire logic                        spi_reset_seen,
    input  wire logic                        power_on_reset_seen,
    input  wire logic                        reset_pin_seen,
    // Code RAM unlock state of the two channels.
    input  wire logic                        code_ram_a_unlocked,
    input  wire logic                        code_ram_b_unlocked,
    // RAM under test.
    output logic      [RAM_AW-1:0]           bist_ram_addr_r,
    output logic                             bist_ram_we_r,
    output logic                             bist_ram_re_r,
    output logic      [RAM_DW-1:0]           bist_ram_wdata_r,
    input  wire logic [RAM_DW-1:0]           bist_ram_rdata,
    // Write-grant service for lockable registers and data RAM tails.
    input  wire logic                        tgt_wr,
    input  wire logic                        tgt_lockable,
    input  wire logic                        tgt_tail_a,
    input  wire logic                        tgt_tail_b,
    output logic                             tgt_wr_grant_r,
    // Protect state and clear-on-read strobes.
    output logic                             global_lock_r,
    output logic                             data_ram_a_tail_protect_r,
    output logic                             data_ram_b_tail_protect_r,
    input  wire logic [`SLB_COR_TARGETS-1:0] core_wr_hit,
    output logic      [`SLB_COR_TARGETS-1:0] cor_clear_r
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks and shared functions.

    // The run counter is 20 bits and patterns are built from bytes.
    if (BIST_RUN_CYCLES == 0 || BIST_RUN_CYCLES >= (1 << 20) || RAM_DW % 8 != 0
        || RAM_AW == 0 || RAM_AW > 16) begin : g_bad_param
        $error("slb_regs: unsupported parameter value");
    end

    // Pattern byte of phase p; each test writes and checks ten phases, 0 to 9.
    function automatic logic [7:0] pat_byte(input logic [3:0] p);
        case (p)
            4'h0, 4'h6, 4'h9: pat_byte = 8'h00;
            4'h1, 4'h7, 4'h8: pat_byte = 8'hFF;
            4'h2:             pat_byte = 8'h55;
            4'h3:             pat_byte = 8'hAA;
            4'h4:             pat_byte = 8'h0F;
            4'h5:             pat_byte = 8'hF0;
            default:          pat_byte = 8'h00;
        endcase
    endfunction

    // Access qualifiers, shared by several sections.
    wire ext_rd   = reg_rd && !reg_backdoor;                              // External read.
    wire ext_acc  = (reg_rd || reg_wr) && !reg_backdoor;                  // External access.
    wire hit_lock = reg_addr == `SLB_OFS_WRITE_PROTECT;
    wire hit_cor  = reg_addr == `SLB_OFS_CLEAR_ON_READ;
    wire hit_unl  = reg_addr == `SLB_OFS_UNLOCK;
    wire hit_rec  = reg_addr == `SLB_OFS_RESET_CAUSE;
    wire hit_bist = reg_addr == `SLB_OFS_SELFTEST;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset-cause record.

    // The record is not cleared by the main reset, since it must outlive the resets
    // that it records; the sources are sampled while reset is held.
    logic [2:0] cause_r;
    wire  [2:0] cause_evt = {spi_reset_seen, power_on_reset_seen, reset_pin_seen};
    wire  [2:0] cause_nxt = (ext_acc && hit_rec ? 3'h0 : cause_r) | cause_evt;

    // A source seen in the clearing cycle survives: the set wins. The pin flag may be
    // left over from before power-on, which is allowed.
    always_ff @(posedge mclk) begin
        cause_r <= cause_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write protection.

    logic [2:0] lock_r; // Tail B, tail A, global.
    wire unlock_wr = reg_wr && hit_unl && reg_wdata == `SLB_KEY_UNLOCK;
    wire lock_wr   = reg_wr && hit_lock;
    // Each bit only ever sets from a write; the global bit also locks its own bit.
    wire [2:0] lock_set = {reg_wdata[`SLB_BIT_TAIL_B_LOCK], reg_wdata[`SLB_BIT_TAIL_A_LOCK],
                           reg_wdata[`SLB_BIT_GLOBAL_LOCK] && !lock_r[`SLB_BIT_GLOBAL_LOCK]};
    wire [2:0] lock_nxt = unlock_wr ? `SLB_RST_LOCK :
                          lock_r | (lock_wr ? lock_set : 3'h0);

    // Tail writes ignore the global bit; other lockable writes ignore the tail bits.
    wire grant_nxt = tgt_wr &&
                     !(tgt_tail_a && lock_r[`SLB_BIT_TAIL_A_LOCK]) &&
                     !(tgt_tail_b && lock_r[`SLB_BIT_TAIL_B_LOCK]) &&
                     !(!tgt_tail_a && !tgt_tail_b && tgt_lockable &&
                       lock_r[`SLB_BIT_GLOBAL_LOCK]);

    // Protect bits and the registered grant.
    always_ff @(posedge mclk) begin
        if (reset) begin
            lock_r         <= `SLB_RST_LOCK;
            tgt_wr_grant_r <= 1'b0;
        end else begin
            lock_r         <= lock_nxt;
            tgt_wr_grant_r <= grant_nxt;
        end
    end

    assign global_lock_r             = lock_r[`SLB_BIT_GLOBAL_LOCK];
    assign data_ram_a_tail_protect_r = lock_r[`SLB_BIT_TAIL_A_LOCK];
    assign data_ram_b_tail_protect_r = lock_r[`SLB_BIT_TAIL_B_LOCK];

    ////////////////////////////////////////////////////////////////////////////////
    // Clear-on-read selection and strobes.

    logic [`SLB_COR_TARGETS-1:0] cor_sel_r;
    wire  [`SLB_COR_TARGETS-1:0] cor_hit;
    wire  [8:0]                  diag_rel = reg_addr - `SLB_OFS_DIAG_FIRST;

    assign cor_hit[0] = reg_addr == DRV_STATUS_OFS;
    // Each diagnosis pair and each core status register has its own enable bit.
    for (genvar i = 0; i < 4; i++) begin : g_cor
        assign cor_hit[1+i] = reg_addr >= `SLB_OFS_DIAG_FIRST &&
                              reg_addr <= `SLB_OFS_DIAG_LAST && diag_rel[2:1] == 2'(i);
        assign cor_hit[5+i] = reg_addr == CORE_STAT_BASE + 9'(i);
    end

    // Backdoor reads are excluded, and a colliding core write cancels the clear so
    // the updated value shows at the next external read.
    wire [`SLB_COR_TARGETS-1:0] cor_nxt = {`SLB_COR_TARGETS{ext_rd}} & cor_hit &
                                          cor_sel_r & ~core_wr_hit;

    // Enable bits are not lockable; strobes last one cycle.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cor_sel_r   <= `SLB_RST_COR_SEL;
            cor_clear_r <= '0;
        end else begin
            if (reg_wr && hit_cor) begin
                cor_sel_r <= reg_wdata[`SLB_COR_TARGETS-1:0];
            end
            cor_clear_r <= cor_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Memory self-test sequencer.

    slb_state_t   st_r;
    slb_outcome_t outcome_r;
    logic [3:0]   phase_r;  // Pattern phase 0..9.
    logic [19:0]  run_r;    // Cycles since start.
    logic         chk_r;    // Read data due this cycle.
    logic         bad_r;    // A mismatch was seen.
    logic [RAM_DW-1:0] exp_r;

    wire start_ok  = reg_wr && hit_bist && reg_wdata == `SLB_KEY_SELFTEST &&
                     code_ram_a_unlocked && code_ram_b_unlocked &&
                     st_r == SLB_ST_IDLE;
    wire addr_last = &bist_ram_addr_r;
    wire run_done  = run_r >= 20'(BIST_RUN_CYCLES - 1);
    wire [RAM_DW-1:0] pat_word = {(RAM_DW/8){pat_byte(phase_r)}};
    wire mismatch  = chk_r && bist_ram_rdata != exp_r;

    // Each phase fills the RAM and reads it back; the result is posted no earlier than
    // the documented run time so software sees the same timing on any RAM depth whose ten phases end within it.
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r      <= SLB_ST_IDLE;
            outcome_r <= SLB_OUT_NEVER;
            phase_r   <= 4'h0;
            run_r     <= 20'h0;
            chk_r     <= 1'b0;
            bad_r     <= 1'b0;
            exp_r     <= '0;
            bist_ram_addr_r  <= '0;
            bist_ram_we_r    <= 1'b0;
            bist_ram_re_r    <= 1'b0;
            bist_ram_wdata_r <= '0;
        end else begin
            chk_r <= bist_ram_re_r;
            exp_r <= bist_ram_wdata_r;
            bad_r <= bad_r | mismatch;
            run_r <= (st_r == SLB_ST_IDLE || run_done) ? run_r : run_r + 20'h1;
            case (st_r)
                SLB_ST_IDLE: begin
                    if (start_ok) begin
                        st_r      <= SLB_ST_WRITE;
                        outcome_r <= SLB_OUT_RUNNING;
                        phase_r   <= 4'h0;
                        run_r     <= 20'h0;
                        bad_r     <= 1'b0;
                        bist_ram_addr_r <= '0;
                    end
                end
                SLB_ST_WRITE: begin
                    bist_ram_we_r    <= !(bist_ram_we_r && addr_last);
                    bist_ram_wdata_r <= pat_word;
                    if (bist_ram_we_r) begin
                        bist_ram_addr_r <= bist_ram_addr_r + 1'b1;
                        if (addr_last) begin
                            st_r <= SLB_ST_READ;
                        end
                    end
                end
                SLB_ST_READ: begin
                    bist_ram_re_r <= !(bist_ram_re_r && addr_last);
                    if (bist_ram_re_r) begin
                        bist_ram_addr_r <= bist_ram_addr_r + 1'b1;
                        if (addr_last) begin
                            st_r <= SLB_ST_DRAIN;
                        end
                    end
                end
                SLB_ST_DRAIN: begin
                    // Last read data lands now; then next phase or finish.
                    if (!chk_r) begin
                        phase_r <= phase_r + 4'h1;
                        st_r    <= (phase_r == 4'h9) ? SLB_ST_HOLD : SLB_ST_WRITE;
                    end
                end
                SLB_ST_HOLD: begin
                    if (run_done) begin
                        st_r      <= SLB_ST_IDLE;
                        outcome_r <= bad_r ? SLB_OUT_FAILED : SLB_OUT_PASSED;
                    end
                end
                default: st_r <= SLB_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data.

    wire [15:0] rd_mux = hit_lock ? {13'h0, lock_r} :
                         hit_cor  ? {7'h0, cor_sel_r} :
                         hit_rec  ? {13'h0, cause_r} :
                         hit_bist ? {14'h0, outcome_r} :
                                    `SLB_RST_DATA;

    // Read data is captured on every read and held until the next one.
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata_r <= `SLB_RST_DATA;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    cause_set_a: assert property (power_on_reset_seen |=> cause_r[1])
        else $error("power-on source not recorded");
    cause_clear_a: assert property (ext_rd && hit_rec && cause_evt == 3'h0
        |=> cause_r == 3'h0 ##0 reg_rdata_r == {13'h0, $past(cause_r)})
        else $error("reset record not returned and cleared");
    bist_start_a: assert property (start_ok |=> outcome_r == SLB_OUT_RUNNING
        ##1 (outcome_r == SLB_OUT_RUNNING) [*8])
        else $error("self-test did not start");
    bist_refuse_a: assert property (reg_wr && hit_bist && !start_ok
        && st_r == SLB_ST_IDLE |=> $stable(outcome_r))
        else $error("refused start changed the outcome");
    bist_locked_a: assert property (reg_wr && hit_bist && !code_ram_a_unlocked
        && st_r == SLB_ST_IDLE |=> st_r == SLB_ST_IDLE)
        else $error("self-test started with code RAM locked");
    bist_read_a: assert property (reg_rd && hit_bist
        |=> reg_rdata_r == {14'h0, $past(outcome_r)})
        else $error("self-test outcome misread");
    lock_sticky_a: assert property (global_lock_r && !unlock_wr |=> global_lock_r)
        else $error("global protect cleared without key");
    unlock_all_a: assert property (unlock_wr |=> lock_r == 3'h0)
        else $error("unlock key left protect bits set");
    protect_wr_a: assert property (tgt_wr && tgt_lockable && !tgt_tail_a && !tgt_tail_b
        && global_lock_r |=> !tgt_wr_grant_r)
        else $error("protected write granted");
    tail_guard_a: assert property (tgt_wr && tgt_tail_a && global_lock_r
        && !tgt_tail_b && !data_ram_a_tail_protect_r |=> tgt_wr_grant_r)
        else $error("tail write wrongly refused");
    cor_strobe_a: assert property (ext_rd && reg_addr == `SLB_OFS_DIAG_LAST
        && cor_sel_r[4] && !core_wr_hit[4] |=> cor_clear_r == 9'h010
        ##1 (cor_clear_r == 9'h0 || $past(reg_rd)))
        else $error("diagnosis clear strobe wrong");
    cor_backdoor_a: assert property (reg_rd && reg_backdoor |=> cor_clear_r == 9'h0)
        else $error("backdoor read cleared a register");

endmodule

// ==== tb/slb_ram_model.sv ====
// Behavioural RAM that the self-test sequencer walks, with a read-data fault switch.
// Assumes one access per cycle; read data comes back one cycle after the read enable.
module slb_ram_model #(
    parameter int unsigned AW = 2,
    parameter int unsigned DW = 8
) (
    input  wire logic          mclk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic          re,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          fault,
    output logic      [DW-1:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DW-1:0] mem [2**AW];    // Storage cells.
    logic [DW-1:0] pats [$];       // Write patterns in the order they appeared, each logged when it differs from the previous write.

    initial rdata = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Store writes and log each new pattern, answer reads one cycle later.
    // Outside a read the data lines toggle, so a stale sample can never pass.
    always @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
            if (pats.size() == 0 || pats[$] !== wdata) begin
                pats.push_back(wdata);
            end
        end
        if (re) begin
            rdata <= mem[addr] ^ {{(DW-1){1'b0}}, fault};
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// ==== tb/system_lock_bist_reset_regs_test.sv ====
// Self-checking bench for the lock, self-test and reset-cause register bank.
// Assumes the bank under a shortened self-test run and a small RAM model beside it.
`include "slb_defs.svh"
module system_lock_bist_reset_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import slb_pkg::*;
    logic        mclk, reset, reg_wr, reg_rd, reg_backdoor, ua, ub, fault;
    logic        tgt_wr, tgt_lockable, tgt_tail_a, tgt_tail_b, rd_d, wr_d, gl, ta, tb;
    logic [8:0]  reg_addr, core_wr_hit, cor_clear_r, sel, a;
    logic [15:0] reg_wdata, reg_rdata_r, exp_q [$], msk_q [$];
    logic [8:0]  cor_q [$];
    logic        g_q [$], we, re, grant;
    logic [2:0]  src_r;
    logic [1:0]  ram_addr;
    logic [7:0]  ram_wd, ram_rd;
    logic [7:0]  pat_x [9] = '{8'h00, 8'hFF, 8'h55, 8'hAA, 8'h0F, 8'hF0, 8'h00, 8'hFF, 8'h00};
    int          err_count, checks, n;

    slb_regs #(.RAM_AW(2), .RAM_DW(8), .BIST_RUN_CYCLES(50)) slb_regs_i (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_backdoor(reg_backdoor), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .spi_reset_seen(src_r[2]), .power_on_reset_seen(src_r[1]),
        .reset_pin_seen(src_r[0]), .code_ram_a_unlocked(ua), .code_ram_b_unlocked(ub),
        .bist_ram_addr_r(ram_addr), .bist_ram_we_r(we), .bist_ram_re_r(re),
        .bist_ram_wdata_r(ram_wd), .bist_ram_rdata(ram_rd), .tgt_wr(tgt_wr),
        .tgt_lockable(tgt_lockable), .tgt_tail_a(tgt_tail_a), .tgt_tail_b(tgt_tail_b),
        .tgt_wr_grant_r(grant), .global_lock_r(gl), .data_ram_a_tail_protect_r(ta),
        .data_ram_b_tail_protect_r(tb), .core_wr_hit(core_wr_hit), .cor_clear_r(cor_clear_r));

    slb_ram_model #(.AW(2), .DW(8)) slb_ram_model_i (
        .mclk(mclk), .addr(ram_addr), .we(we), .re(re), .wdata(ram_wd), .fault(fault),
        .rdata(ram_rd));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: a read answer and any clear strobe land one cycle after the request,
    // so the oldest note is compared at the following falling edge.
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        wr_d <= tgt_wr;
    end
    always @(negedge mclk) begin
        if (rd_d) begin
            checks++;
            if ((reg_rdata_r & msk_q[0]) !== (exp_q[0] & msk_q[0]) || cor_clear_r !== cor_q[0]) begin
                err_count++;
                $display("[FAIL] %0t read %h strobe %h, expected %h %h", $time, reg_rdata_r,
                         cor_clear_r, exp_q[0], cor_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
            void'(cor_q.pop_front());
        end
        if (wr_d) begin
            checks++;
            if (grant !== g_q[0]) begin
                err_count++;
                $display("[FAIL] %0t write grant %b, expected %b", $time, grant, g_q[0]);
            end
            void'(g_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks: strobes rise after one edge and fall at the next, never twice in a step.
    task automatic rd(input logic [8:0] ad, input logic [15:0] e, input logic [8:0] c = '0,
                      input logic [15:0] m = 16'hFFFF, input logic bd = 1'b0,
                      input logic [8:0] hit = '0);
        exp_q.push_back(e);
        msk_q.push_back(m);
        cor_q.push_back(c);
        @(posedge mclk);
        reg_addr     <= ad;
        reg_backdoor <= bd;
        core_wr_hit  <= hit;
        reg_rd       <= 1'b1;
        @(posedge mclk);
        reg_rd       <= 1'b0;
        core_wr_hit  <= '0;
    endtask

    task automatic wr(input logic [8:0] ad, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Target write request; k is {tail_b, tail_a, lockable}.
    task automatic tg(input logic [2:0] k, input logic e);
        g_q.push_back(e);
        @(posedge mclk);
        {tgt_tail_b, tgt_tail_a, tgt_lockable} <= k;
        tgt_wr <= 1'b1;
        @(posedge mclk);
        tgt_wr <= 1'b0;
    endtask

    // The protect levels on the pins must follow the protect register at once.
    task automatic pins(input logic [2:0] e);
        checks++;
        if ({tb, ta, gl} !== e) begin
            err_count++;
            $display("[FAIL] %0t protect pins %b, expected %b", $time, {tb, ta, gl}, e);
        end
    endtask

    // One-cycle pulse on reset source i.
    task automatic src(input int i);
        @(posedge mclk);
        src_r[i] <= 1'b1;
        @(posedge mclk);
        src_r[i] <= 1'b0;
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
    endtask

    // Every register of the bank except the reset-cause record reads zero after reset; so do unmapped and write-only places.
    task automatic zero_reads();
        rd(`SLB_OFS_WRITE_PROTECT, 16'h0000);
        rd(`SLB_OFS_CLEAR_ON_READ, 16'h0000);
        rd(`SLB_OFS_SELFTEST, 16'h0000);
        rd(`SLB_OFS_UNLOCK, 16'h0000);
        rd(9'h000, 16'h0000);
    endtask

    task automatic final_report();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short long after the whole sequence should have ended.
    initial begin
        #80000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {reg_wr, reg_rd, reg_backdoor, tgt_wr, tgt_lockable, tgt_tail_a, tgt_tail_b} = '0;
        {ua, ub, fault, rd_d, wr_d} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        core_wr_hit = '0;
        src_r = 3'b111;
        void'($urandom(98));
        do_reset();
        src_r <= 3'b000;
        rd(`SLB_OFS_RESET_CAUSE, 16'h0006, 9'h000, 16'hFFFE);
        rd(`SLB_OFS_RESET_CAUSE, 16'h0000);
        zero_reads();
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            src(i);
            rd(`SLB_OFS_RESET_CAUSE, 16'h0001 << i);
        end
        src(0);
        rd(`SLB_OFS_RESET_CAUSE, 16'h0001, 9'h000, 16'hFFFF, 1'b1);
        rd(`SLB_OFS_RESET_CAUSE, 16'h0001);
        src(2);
        wr(`SLB_OFS_RESET_CAUSE, 16'($urandom));
        rd(`SLB_OFS_RESET_CAUSE, 16'h0000);
        $display("reset cause done");
        tg(3'b001, 1'b1);
        wr(`SLB_OFS_WRITE_PROTECT, 16'h0001);
        tg(3'b001, 1'b0);
        tg(3'b011, 1'b1);
        tg(3'b000, 1'b1);
        wr(`SLB_OFS_WRITE_PROTECT, 16'h0000);
        rd(`SLB_OFS_WRITE_PROTECT, 16'h0001);
        pins(3'b001);
        wr(`SLB_OFS_WRITE_PROTECT, 16'h0007);
        rd(`SLB_OFS_WRITE_PROTECT, 16'h0007);
        pins(3'b111);
        tg(3'b011, 1'b0);
        tg(3'b101, 1'b0);
        wr(`SLB_OFS_UNLOCK, `SLB_KEY_UNLOCK ^ 16'h0001);
        rd(`SLB_OFS_WRITE_PROTECT, 16'h0007);
        wr(`SLB_OFS_UNLOCK, `SLB_KEY_UNLOCK);
        rd(`SLB_OFS_WRITE_PROTECT, 16'h0000);
        pins(3'b000);
        tg(3'b001, 1'b1);
        $display("write protection done");
        for (int p = 0; p < 2; p++) begin
            sel = p ? ~sel : 9'($urandom);
            wr(`SLB_OFS_CLEAR_ON_READ, {7'h00, sel});
            rd(`SLB_OFS_CLEAR_ON_READ, {7'h00, sel});
            for (int i = 0; i < 9; i++) begin
                a = (i == 0) ? `SLB_OFS_DRV_STATUS : (i < 5) ?
                    9'(`SLB_OFS_DIAG_FIRST + 2 * (i - 1) + (i == 4 ? sel[4] : $urandom % 2)) :
                    9'(`SLB_OFS_CORE_STAT_BASE + i - 5);
                rd(a, 16'h0000, sel & (9'h001 << i), 16'h0000);
                rd(a, 16'h0000, 9'h000, 16'h0000, 1'b1);
                rd(a, 16'h0000, 9'h000, 16'h0000, 1'b0, 9'h001 << i);
            end
        end
        $display("clear on read done");
        ua <= 1'b1;
        wr(`SLB_OFS_SELFTEST, `SLB_KEY_SELFTEST);
        rd(`SLB_OFS_SELFTEST, 16'h0000);
        ub <= 1'b1;
        wr(`SLB_OFS_SELFTEST, `SLB_KEY_SELFTEST ^ 16'h8000);
        rd(`SLB_OFS_SELFTEST, 16'h0000);
        for (int f = 0; f < 2; f++) begin
            fault <= f[0];
            slb_ram_model_i.pats.delete();
            wr(`SLB_OFS_SELFTEST, `SLB_KEY_SELFTEST);
            rd(`SLB_OFS_SELFTEST, 16'h0001);
            wr(`SLB_OFS_SELFTEST, `SLB_KEY_SELFTEST);
            n = 0;
            do begin
                rd(`SLB_OFS_SELFTEST, 16'h0000, 9'h000, 16'h0000);
                #1;
                n++;
            end while (reg_rdata_r[1:0] === 2'h1 && n < 400);
            rd(`SLB_OFS_SELFTEST, f ? 16'h0003 : 16'h0002);
            for (int k = 0; k < 9 && f == 0; k++) begin
                checks++;
                if (slb_ram_model_i.pats.size() != 9 || slb_ram_model_i.pats[k] !== pat_x[k]) begin
                    err_count++;
                    $display("[FAIL] %0t pattern %0d wrong", $time, k);
                end
            end
        end
        $display("self-test done");
        wr(`SLB_OFS_WRITE_PROTECT, 16'h0007);
        wr(`SLB_OFS_CLEAR_ON_READ, 16'h01FF);
        do_reset();
        zero_reads();
        $display("second reset done");
        final_report();
    end
endmodule
